//--- hdl/ois_defs.svh
// constants of the octal input serializer: timing, register map, field positions
`ifndef OIS_DEFS_SVH
`define OIS_DEFS_SVH
// ***********************************
// clock and timing
// ***********************************
`define CLK_PERIOD_NS 25
`define DB_LONG_US    3000
`define DB_SHORT_US   1000
`define SUP_FALL_US   1000
`define SUP_RISE_US   6000
// least time, rounded up to whole cycles
`define US_TO_CYC(us) (((us) * 1000 + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define CH_COUNT      8
`define CNT_WIDTH     18
// ***********************************
// register map (byte addresses)
// ***********************************
`define REG_STATUS    4'h0
`define REG_MASK      4'h4
`define REG_SNAPSHOT  4'h8
`define REG_CONTROL   4'hc
// event bits of status and mask
`define EV_SUP        0
`define EV_OKLOW      1
`define EV_SHDN       2
`define EV_RSV        3
`define EV_W          4
// snapshot fields
`define SNAP_FILT     0
`define SNAP_SHREG    8
`define SNAP_OK       16
`define SNAP_SHDN     17
`define SNAP_SEL      18
// control fields
`define CTL_OVR       0
`define CTL_SEL       1
`define CTL_W         3
`endif

//--- hdl/ois_pkg.sv
// types of the octal input serializer
package ois_pkg;
   // supply monitor states
   typedef enum logic [1:0] {SUP_OK, SUP_FALLING, SUP_FAULT, SUP_RECOVER} sup_state_t;
   // debounce select {high pin, low pin}; 1 = open
   typedef enum logic [1:0] {DB_RESERVED, DB_BYPASS, DB_SHORT, DB_LONG} db_mode_t;
endpackage

//--- hdl/octal_input_serializer_health.sv
// octal field input serializer with debounce, shift register and health output
// Functional notes
// - accept level only after stable whole interval
// - select pins choose 3 ms, 1 ms, bypass
// - eight-stage shift register drives serial output
// - capture low: stages copy filtered inputs
// - capture high: no parallel capture
// - clock rise, enable low: shift, take cascade
// - enable high: no shift; capture low still loads the stages
// - supply below 15 V: health low after 1 ms
// - supply recovered: health low further 6 ms
// - below 10 V stops; health high 6 ms later
// - over-temperature fault forces health low
// - second trip point tri-states serial and health outputs
// - health is AND of both fault-free signals
// - tri-stated health line reads low
`timescale 1ns/1ps
`include "ois_defs.svh"

module octal_input_serializer_health #(
   parameter int NCH           = `CH_COUNT,
   parameter int CW            = `CNT_WIDTH,
   parameter int AW            = 4,
   parameter bit FIRST_CH_HIGH = 1'b1,
   parameter int DB_LONG_CYC   = `US_TO_CYC(`DB_LONG_US),
   parameter int DB_SHORT_CYC  = `US_TO_CYC(`DB_SHORT_US),
   parameter int SUP_FALL_CYC  = `US_TO_CYC(`SUP_FALL_US),
   parameter int SUP_RISE_CYC  = `US_TO_CYC(`SUP_RISE_US)
) (
   // clock and reset
   input  wire logic           clk_i,
   input  wire logic           rst_i,
   // wishbone slave
   input  wire logic           wb_cyc_i,
   input  wire logic           wb_stb_i,
   input  wire logic           wb_we_i,
   input  wire logic [AW-1:0]  wb_adr_i,
   input  wire logic [31:0]    wb_dat_i,
   input  wire logic [3:0]     wb_sel_i,
   output logic      [31:0]    wb_dat_o,
   output logic                wb_ack_o,
   output logic                irq_o,
   // field side
   input  wire logic [NCH-1:0] field_channel_inputs_i,
   input  wire logic           debounce_select_low_i,
   input  wire logic           debounce_select_high_i,
   // monitors: supply below 15 V, below 10 V, temperature trips
   input  wire logic           supply_low_i,
   input  wire logic           supply_dead_i,
   input  wire logic           over_temp_n_i,
   input  wire logic           thermal_shutdown_i,
   // serial link from the controller
   input  wire logic           parallel_capture_n_i,
   input  wire logic           clock_enable_n_i,
   input  wire logic           shift_clock_i,
   input  wire logic           cascade_serial_in_i,
   output logic                serial_data_out_o,
   output logic                serial_data_out_oe_o,
   // health line
   output logic                chip_health_ok_o,
   output logic                chip_health_ok_oe_o
);
   import ois_pkg::*;

   // ***********************************
   // state
   // ***********************************
   typedef struct packed {
      logic [NCH-1:0]         fld_s1, fld_s2;         // raw field inputs, two stages
      logic [1:0]             sel_s1, sel_s2;         // debounce select {high, low}
      logic                   sck_s1, sck_s2, sck_d;  // link clock, two stages and previous level
      logic                   ce_s1, ce_s2;           // clock enable, active low
      logic                   cap_s1, cap_s2;         // capture, active low
      logic                   sip_s1, sip_s2;         // cascade input
      logic                   low_s1, low_s2;         // supply below 15 V
      logic                   dead_s1, dead_s2;       // supply below 10 V
      logic                   otn_s1, otn_s2;         // over-temperature, active low
      logic                   shd_s1, shd_s2;         // thermal shutdown
      logic [NCH-1:0]         filt;     // debounced channel states
      logic [NCH-1:0][CW-1:0] db_cnt;   // per-channel stability counters
      logic [NCH-1:0]         shreg;    // shift register
      sup_state_t             sup;      // supply monitor state
      logic [CW-1:0]          sup_cnt;  // supply monitor timer
      logic [`EV_W-1:0]       status;   // sticky events
      logic [`EV_W-1:0]       mask;     // interrupt enables
      logic [`CTL_W-1:0]      ctl;      // select override
      logic                   ack;
      logic [31:0]            dat;
      logic                   irq;
      logic                   sop;
      logic                   sop_oe;
      logic                   ok;
      logic                   ok_oe;
   } state_t;

   state_t           r_reg;      // registered state
   state_t           r_next;     // next state
   db_mode_t         mode;       // active debounce mode
   logic [CW-1:0]    limit;      // last count of the interval
   logic [NCH-1:0]   load_word;  // filtered states in stage order
   logic             shift_now;  // qualified link clock rise
   logic             sup_ok;     // supply fault-free, active high
   logic             req;        // bus request present
   logic [`EV_W-1:0] ev;         // events this cycle
   logic [`EV_W-1:0] clr;        // write-one-to-clear bits

   // ***********************************
   // next-state logic
   // ***********************************
   always_comb begin
      r_next = r_reg;
      // two-flop synchronisers; only stage 2 is read by logic
      {r_next.fld_s1, r_next.sel_s1} = {field_channel_inputs_i, debounce_select_high_i, debounce_select_low_i};
      {r_next.fld_s2, r_next.sel_s2} = {r_reg.fld_s1, r_reg.sel_s1};
      {r_next.sck_s1, r_next.ce_s1, r_next.cap_s1, r_next.sip_s1} =
         {shift_clock_i, clock_enable_n_i, parallel_capture_n_i, cascade_serial_in_i};
      {r_next.sck_s2, r_next.ce_s2, r_next.cap_s2, r_next.sip_s2} =
         {r_reg.sck_s1, r_reg.ce_s1, r_reg.cap_s1, r_reg.sip_s1};
      {r_next.low_s1, r_next.dead_s1, r_next.otn_s1, r_next.shd_s1} =
         {supply_low_i, supply_dead_i, over_temp_n_i, thermal_shutdown_i};
      {r_next.low_s2, r_next.dead_s2, r_next.otn_s2, r_next.shd_s2} =
         {r_reg.low_s1, r_reg.dead_s1, r_reg.otn_s1, r_reg.shd_s1};
      r_next.sck_d = r_reg.sck_s2;
      // software override of the select pins, else the pins
      if (r_reg.ctl[`CTL_OVR]) begin
         mode = db_mode_t'(r_reg.ctl[`CTL_SEL +: 2]);
      end else begin
         mode = db_mode_t'(r_reg.sel_s2);
      end
      // reserved code falls back to the longest filter, the safe side
      if (mode == DB_SHORT) begin
         limit = CW'(DB_SHORT_CYC - 1);
      end else begin
         limit = CW'(DB_LONG_CYC - 1);
      end

      // per-channel debounce: a differing level must persist the interval
      for (int i = 0; i < NCH; i++) begin
         if (mode == DB_BYPASS) begin
            r_next.filt[i]   = r_reg.fld_s2[i];
            r_next.db_cnt[i] = '0;
         end else if (r_reg.fld_s2[i] == r_reg.filt[i]) begin
            r_next.db_cnt[i] = '0;
         end else if (r_reg.db_cnt[i] >= limit) begin
            r_next.filt[i]   = r_reg.fld_s2[i];
            r_next.db_cnt[i] = '0;
         end else begin
            r_next.db_cnt[i] = r_reg.db_cnt[i] + 1'b1;
         end
      end

      // stage order: top stage leaves first
      for (int i = 0; i < NCH; i++) begin
         load_word[i] = FIRST_CH_HIGH ? r_reg.filt[i] : r_reg.filt[NCH-1-i];
      end

      // shift register; a dead supply freezes it
      shift_now = r_reg.sck_s2 & ~r_reg.sck_d & r_reg.cap_s2 & ~r_reg.ce_s2 & ~r_reg.dead_s2;
      if (!r_reg.dead_s2) begin
         if (!r_reg.cap_s2) begin
            r_next.shreg = load_word;
         end else if (shift_now) begin
            r_next.shreg = {r_reg.shreg[NCH-2:0], r_reg.sip_s2};
         end
         // otherwise hold: no capture, no shift
      end

      // supply monitor
      unique case (r_reg.sup)
         SUP_OK: begin
            if (r_reg.dead_s2) begin
               r_next.sup = SUP_FAULT;
            end else if (r_reg.low_s2) begin
               r_next.sup     = SUP_FALLING;
               r_next.sup_cnt = '0;
            end
         end
         SUP_FALLING: begin
            if (r_reg.dead_s2) begin
               r_next.sup = SUP_FAULT;
            end else if (!r_reg.low_s2) begin
               r_next.sup = SUP_OK; // dip shorter than the delay
            end else if (r_reg.sup_cnt >= CW'(SUP_FALL_CYC - 1)) begin
               r_next.sup = SUP_FAULT;
            end else begin
               r_next.sup_cnt = r_reg.sup_cnt + 1'b1;
            end
         end
         SUP_FAULT: begin
            if (!r_reg.low_s2 && !r_reg.dead_s2) begin
               r_next.sup     = SUP_RECOVER;
               r_next.sup_cnt = '0;
            end
         end
         SUP_RECOVER: begin
            if (r_reg.low_s2 || r_reg.dead_s2) begin
               r_next.sup = SUP_FAULT; // restart the wait
            end else if (r_reg.sup_cnt >= CW'(SUP_RISE_CYC - 1)) begin
               r_next.sup = SUP_OK;
            end else begin
               r_next.sup_cnt = r_reg.sup_cnt + 1'b1;
            end
         end
      endcase
      sup_ok = (r_reg.sup == SUP_OK) || (r_reg.sup == SUP_FALLING);

      // health and pin drivers; shutdown releases the pins
      r_next.ok     = r_reg.otn_s2 & sup_ok & ~r_reg.shd_s2;
      r_next.ok_oe  = ~r_reg.shd_s2;
      r_next.sop_oe = ~r_reg.shd_s2;
      r_next.sop    = r_next.shreg[NCH-1];
      // events
      ev            = '0;
      ev[`EV_SUP]   = (r_reg.sup != SUP_FAULT) && (r_next.sup == SUP_FAULT);
      ev[`EV_OKLOW] = r_reg.ok & ~r_next.ok;
      ev[`EV_SHDN]  = r_reg.ok_oe & ~r_next.ok_oe;
      ev[`EV_RSV]   = (mode == DB_RESERVED);
      // bus slave: ack one cycle after the request, write on the ack edge
      req         = wb_cyc_i & wb_stb_i;
      r_next.ack  = req & ~r_reg.ack;
      r_next.dat  = '0;
      clr         = '0;
      if (req && !r_reg.ack) begin
         unique case (wb_adr_i)
            `REG_STATUS:   r_next.dat[`EV_W-1:0] = r_reg.status;
            `REG_MASK:     r_next.dat[`EV_W-1:0] = r_reg.mask;
            `REG_SNAPSHOT: begin
               r_next.dat[`SNAP_FILT +: NCH]  = r_reg.filt;
               r_next.dat[`SNAP_SHREG +: NCH] = r_reg.shreg;
               r_next.dat[`SNAP_OK]           = r_reg.ok;
               r_next.dat[`SNAP_SHDN]         = ~r_reg.ok_oe;
               r_next.dat[`SNAP_SEL +: 2]     = mode;
            end
            `REG_CONTROL:  r_next.dat[`CTL_W-1:0] = r_reg.ctl;
            default:       r_next.dat = '0; // unmapped reads zero
         endcase
      end
      if (req && r_reg.ack && wb_we_i && wb_sel_i[0]) begin
         unique case (wb_adr_i)
            `REG_STATUS:  clr = wb_dat_i[`EV_W-1:0];
            `REG_MASK:    r_next.mask = wb_dat_i[`EV_W-1:0];
            `REG_CONTROL: r_next.ctl = wb_dat_i[`CTL_W-1:0];
            default:      clr = '0; // unmapped writes ignored
         endcase
      end
      // a fresh event beats a simultaneous clear
      r_next.status = (r_reg.status & ~clr) | ev;
      r_next.irq    = |(r_next.status & r_next.mask);
   end

   // ***********************************
   // state register
   // ***********************************
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         r_reg <= '0;
         {r_reg.sel_s1, r_reg.sel_s2} <= '1; // selects idle open: no false reserved event
      end else begin
         r_reg <= r_next;
      end
   end

   // outputs straight from the state register
   assign wb_dat_o             = r_reg.dat;
   assign wb_ack_o             = r_reg.ack;
   assign irq_o                = r_reg.irq;
   assign serial_data_out_o    = r_reg.sop;
   assign serial_data_out_oe_o = r_reg.sop_oe;
   assign chip_health_ok_o     = r_reg.ok;
   assign chip_health_ok_oe_o  = r_reg.ok_oe;

   // ***********************************
   // assertions
   // ***********************************
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);
   property p_db_stable;
      (r_reg.filt != $past(r_reg.filt)) && ($past(mode) != DB_BYPASS) |-> ($past(r_reg.db_cnt) != '0)
         && (((r_reg.filt ^ $past(r_reg.filt)) & (r_reg.filt ^ $past(r_reg.fld_s2))) == '0);
   endproperty
   a_db_stable: assert property (p_db_stable) else $error("filter accepted early");
   property p_bypass;
      mode == DB_BYPASS |=> r_reg.filt == $past(r_reg.fld_s2);
   endproperty
   a_bypass: assert property (p_bypass) else $error("bypass not transparent");
   property p_sop;
      serial_data_out_o == r_reg.shreg[NCH-1];
   endproperty
   a_sop: assert property (p_sop) else $error("serial out not last stage");
   property p_capture;
      !r_reg.cap_s2 && !r_reg.dead_s2 |=> r_reg.shreg == $past(load_word);
   endproperty
   a_capture: assert property (p_capture) else $error("capture missed");
   property p_hold;
      r_reg.cap_s2 && !shift_now |=> $stable(r_reg.shreg);
   endproperty
   a_hold: assert property (p_hold) else $error("register changed without shift");
   property p_shift;
      shift_now |=> r_reg.shreg == {$past(r_reg.shreg[NCH-2:0]), $past(r_reg.sip_s2)};
   endproperty
   a_shift: assert property (p_shift) else $error("shift wrong");
   sequence s_fall_done;
      r_reg.sup == SUP_FALLING && r_reg.low_s2 && !r_reg.dead_s2
         && r_reg.sup_cnt == CW'(SUP_FALL_CYC - 1);
   endsequence
   property p_fall;
      s_fall_done |=> r_reg.sup == SUP_FAULT ##1 !chip_health_ok_o;
   endproperty
   a_fall: assert property (p_fall) else $error("supply fault late");
   sequence s_rise_done;
      r_reg.sup == SUP_RECOVER && !r_reg.low_s2 && !r_reg.dead_s2
         && r_reg.sup_cnt == CW'(SUP_RISE_CYC - 1);
   endsequence
   property p_rise;
      (r_reg.sup == SUP_RECOVER |=> !chip_health_ok_o) and (s_rise_done |=> r_reg.sup == SUP_OK);
   endproperty
   a_rise: assert property (p_rise) else $error("recovery wait wrong");
   property p_dead;
      r_reg.dead_s2 |=> r_reg.sup == SUP_FAULT ##1 !chip_health_ok_o;
   endproperty
   a_dead: assert property (p_dead) else $error("dead supply not faulted");
   property p_ovt;
      !r_reg.otn_s2 |=> !chip_health_ok_o;
   endproperty
   a_ovt: assert property (p_ovt) else $error("over-temperature ignored");
   property p_shdn;
      r_reg.shd_s2 |=> !serial_data_out_oe_o && !chip_health_ok_oe_o && !chip_health_ok_o;
   endproperty
   a_shdn: assert property (p_shdn) else $error("outputs not released");
   property p_and;
      chip_health_ok_o == ($past(r_reg.otn_s2) && $past(sup_ok) && !$past(r_reg.shd_s2));
   endproperty
   a_and: assert property (p_and) else $error("health not AND of faults");
endmodule // octal_input_serializer_health

//--- dv/link_controller_model.sv
// link controller model: drives capture, enable, shift clock and cascade toward the serializer
`timescale 1ns/1ps

module link_controller_model (
   // sampling clock of the bench
   input  wire logic clk_i,
   // link toward the device
   output logic      parallel_capture_n_o,
   output logic      clock_enable_n_o,
   output logic      shift_clock_o,
   output logic      cascade_serial_o,
   // serial data back from the device
   input  wire logic serial_data_i
);
   // idle: capture released, shift clock stopped low outside frames
   initial begin
      parallel_capture_n_o = 1'b1;
      clock_enable_n_o     = 1'b1;
      shift_clock_o        = 1'b0;
      cascade_serial_o     = 1'b0;
   end

   // wait a number of system clock edges
   task automatic tick(input int n);
      repeat (n) @(posedge clk_i);
   endtask

   // one frame: capture, then edges rises; bits[k] sampled before rise k
   task automatic frame(input int edges, input logic en_n, input logic [15:0] casc,
                        output logic [15:0] bits);
      bits = '0;
      @(posedge clk_i);
      parallel_capture_n_o <= 1'b0;
      // capture held well beyond the synchroniser depth
      tick(6);
      parallel_capture_n_o <= 1'b1;
      clock_enable_n_o     <= en_n;
      for (int k = 0; k <= edges; k++) begin
         cascade_serial_o <= casc[k];
         tick(4);
         bits[k] = serial_data_i;
         if (k < edges) begin
            // 200 ns shift clock, each level held four cycles
            shift_clock_o <= 1'b1;
            tick(4);
            shift_clock_o <= 1'b0;
         end
      end
      clock_enable_n_o <= 1'b1;
   endtask
endmodule // link_controller_model

//--- dv/tb_top.sv
// self-checking bench of the octal input serializer
`timescale 1ns/1ps
`include "ois_defs.svh"

module tb_top;
   // shortened counts so the run stays brief
   localparam int DBL = 30;
   localparam int DBS = 10;
   localparam int SF  = 20;
   localparam int SR  = 60;
   logic        clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, irq_o;
   logic [3:0]  wb_adr_i, wb_sel_i;
   logic [31:0] wb_dat_i, wb_dat_o, rd;
   logic [7:0]  field_i;
   logic        sel_lo, sel_hi, sup_low, sup_dead, ot_n, shdn;
   logic        cap_n, ce_n, sclk, casc, sop, sop_oe, ok, ok_oe;
   logic [15:0] bits;
   int          n_errors = 0;
   int          n_checks = 0;

   octal_input_serializer_health #(.DB_LONG_CYC(DBL), .DB_SHORT_CYC(DBS), .SUP_FALL_CYC(SF),
      .SUP_RISE_CYC(SR)) octal_input_serializer_health_inst (
      .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
      .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i), .wb_sel_i(wb_sel_i), .wb_dat_o(wb_dat_o),
      .wb_ack_o(wb_ack_o), .irq_o(irq_o), .field_channel_inputs_i(field_i),
      .debounce_select_low_i(sel_lo), .debounce_select_high_i(sel_hi), .supply_low_i(sup_low),
      .supply_dead_i(sup_dead), .over_temp_n_i(ot_n), .thermal_shutdown_i(shdn),
      .parallel_capture_n_i(cap_n), .clock_enable_n_i(ce_n), .shift_clock_i(sclk),
      .cascade_serial_in_i(casc), .serial_data_out_o(sop), .serial_data_out_oe_o(sop_oe),
      .chip_health_ok_o(ok), .chip_health_ok_oe_o(ok_oe));

   link_controller_model link_controller_model_inst (.clk_i(clk_i), .parallel_capture_n_o(cap_n),
      .clock_enable_n_o(ce_n), .shift_clock_o(sclk), .cascade_serial_o(casc), .serial_data_i(sop));

   // 40 MHz system clock
   initial begin
      clk_i = 1'b0;
      forever #12.5 clk_i = ~clk_i;
   end

   // compare one result, count it, report a mismatch at once
   task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
      n_checks++;
      if (got !== exp) begin
         n_errors++;
         $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
      end
   endtask

   task automatic tick(input int n);
      repeat (n) @(posedge clk_i);
   endtask

   // classic single wishbone cycle, held until ack is sampled high
   task automatic wb(input logic we, input logic [3:0] adr, input logic [31:0] wd);
      int t;
      t = 0;
      @(posedge clk_i);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i  <= we;
      wb_adr_i <= adr;
      wb_dat_i <= wd;
      do begin
         @(posedge clk_i);
         t++;
      end while (wb_ack_o !== 1'b1 && t < 50);
      rd = wb_dat_o;
      if (t >= 50) chk("wb ack", 32'h1, 32'h0);
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
      wb_we_i  <= 1'b0;
   endtask

   // wait a bounded time for the health line to reach a level
   task automatic wait_ok(input logic v, input int lim, input string name);
      int t;
      t = 0;
      while (ok !== v && t < lim) begin
         tick(1);
         t++;
      end
      chk(name, {31'h0, v}, {31'h0, ok});
   endtask

   // capture a pattern and shift it out with two cascade bits behind it
   task automatic t_load(input logic [7:0] fld, input logic [1:0] cs);
      logic [15:0] e;
      e = {6'h0, cs[1], cs[0], fld[0], fld[1], fld[2], fld[3], fld[4], fld[5], fld[6], fld[7]};
      field_i <= fld;
      // the select pins give bypass here; the wait still covers the long filter before the capture copies them
      tick(DBL + 12);
      link_controller_model_inst.frame(9, 1'b0, {14'h0, cs}, bits);
      chk("serial frame", {16'h0, e}, {16'h0, bits});
   endtask

   // enable held high: output frozen; capture released: no parallel update
   task automatic t_inhibit;
      field_i <= 8'h81;
      tick(DBL + 12);
      link_controller_model_inst.frame(4, 1'b1, 16'h0, bits);
      chk("inhibited frame", 32'h1f, {16'h0, bits});
      field_i <= 8'h00;
      // long enough for the filtered states to change behind the released capture
      tick(DBL + 12);
      wb(1'b0, `REG_SNAPSHOT, 32'h0);
      chk("shift reg after release", 32'h81, {24'h0, rd[15:8]});
   endtask

   // one debounce mode: mode code, short glitch rejected, long level accepted
   task automatic t_db(input logic hi, input logic lo, input int cyc, input logic [1:0] mode);
      sel_hi  <= hi;
      sel_lo  <= lo;
      field_i <= 8'h00;
      tick(DBL + 12);
      wb(1'b0, `REG_SNAPSHOT, 32'h0);
      chk("debounce mode", {30'h0, mode}, {30'h0, rd[19:18]});
      if (cyc > 0) begin
         field_i <= 8'h01;
         tick(cyc - 2);
         field_i <= 8'h00;
         tick(cyc + 6);
         wb(1'b0, `REG_SNAPSHOT, 32'h0);
         chk("glitch filtered", 32'h0, {24'h0, rd[7:0]});
      end
      field_i <= 8'h01;
      tick(cyc + 8);
      wb(1'b0, `REG_SNAPSHOT, 32'h0);
      chk("level accepted", 32'h1, {24'h0, rd[7:0]});
   endtask

   // reserved select seen earlier, then software override of the select pins
   task automatic t_override;
      wb(1'b0, `REG_STATUS, 32'h0);
      chk("reserved event", 32'h1, {31'h0, rd[`EV_RSV]});
      wb(1'b1, `REG_CONTROL, 32'h5);
      wb(1'b0, `REG_CONTROL, 32'h0);
      chk("control readback", 32'h5, rd);
      wb(1'b0, `REG_SNAPSHOT, 32'h0);
      chk("override mode", 32'h2, {30'h0, rd[19:18]});
      wb(1'b1, `REG_CONTROL, 32'h0);
   endtask

   // supply dip, fault, recovery wait and dead supply
   task automatic t_supply;
      sup_low <= 1'b1;
      tick(SF / 2);
      sup_low <= 1'b0;
      tick(SF + 10);
      chk("short dip", 32'h1, {31'h0, ok});
      sup_low <= 1'b1;
      tick(SF - 6);
      chk("before fall delay", 32'h1, {31'h0, ok});
      wait_ok(1'b0, 16, "supply fault");
      wb(1'b0, `REG_STATUS, 32'h0);
      chk("supply event", 32'h1, {31'h0, rd[`EV_SUP]});
      sup_low <= 1'b0;
      tick(SR - 6);
      chk("recovery hold", 32'h0, {31'h0, ok});
      wait_ok(1'b1, 16, "recovered");
      sup_dead <= 1'b1;
      wait_ok(1'b0, 6, "dead supply");
      sup_dead <= 1'b0;
      tick(SR - 6);
      chk("dead recovery hold", 32'h0, {31'h0, ok});
      wait_ok(1'b1, 16, "dead recovered");
   endtask

   // over-temperature with interrupt, then shutdown releases the outputs
   task automatic t_temp;
      wb(1'b1, `REG_STATUS, 32'hf);
      wb(1'b1, `REG_MASK, 32'h2);
      wb(1'b0, `REG_MASK, 32'h0);
      chk("mask readback", 32'h2, rd);
      wb(1'b0, 4'h2, 32'h0);
      chk("unmapped read", 32'h0, rd);
      ot_n <= 1'b0;
      wait_ok(1'b0, 8, "over temp");
      tick(3);
      chk("irq raised", 32'h1, {31'h0, irq_o});
      ot_n <= 1'b1;
      wait_ok(1'b1, 8, "temp cleared");
      wb(1'b1, `REG_STATUS, 32'h2);
      tick(3);
      chk("irq cleared", 32'h0, {31'h0, irq_o});
      shdn <= 1'b1;
      tick(6);
      chk("shutdown outputs", 32'h0, {29'h0, sop_oe, ok_oe, ok});
      shdn <= 1'b0;
      tick(6);
      chk("outputs back", 32'h3, {30'h0, sop_oe, ok_oe});
      wb(1'b0, `REG_STATUS, 32'h0);
      chk("shutdown event", 32'h1, {31'h0, rd[`EV_SHDN]});
      wait_ok(1'b1, 8, "health back");
   endtask

   // verdict and end of run
   task automatic results;
      $display("checks %0d errors %0d", n_checks, n_errors);
      if (n_errors == 0 && n_checks > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask

   // hang guard, far above the expected length of the run
   initial begin
      #(25 * 30000);
      n_errors++;
      results();
   end

   // main sequence
   initial begin
      rst_i = 1'b1;
      {wb_cyc_i, wb_stb_i, wb_we_i, sup_low, sup_dead, shdn} = '0;
      {wb_adr_i, wb_dat_i, field_i} = '0;
      wb_sel_i = 4'hf;
      {sel_hi, sel_lo, ot_n} = 3'b011;
      tick(2);
      chk("reset outputs", 32'h0, {26'h0, wb_ack_o, irq_o, sop, sop_oe, ok, ok_oe});
      rst_i <= 1'b0;
      tick(10);
      t_load(8'ha5, 2'b10);
      t_load(8'h3c, 2'b01);
      t_inhibit();
      t_db(1'b1, 1'b1, DBL, 2'd3);
      t_db(1'b1, 1'b0, DBS, 2'd2);
      t_db(1'b0, 1'b0, DBL, 2'd0);
      t_db(1'b0, 1'b1, 0, 2'd1);
      t_override();
      t_supply();
      t_temp();
      results();
   end
endmodule // tb_top
